// >>> design/pbsel_top.v
// Port B upper pins: latch, direction, analog select, read path and arbitration
`include "pbsel_map.vh"
module pbsel_top (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] port_pins_7_to_4_i,
  output wire [3:0] port_pins_7_to_4_o,
  output wire [3:0] port_pins_7_to_4_oe_o,
  input wire sdp_sda_oe_i,
  input wire sdp_sda_out_i,
  input wire sdp_sda_take_i,
  input wire uart_receive_sync_data_oe_i,
  input wire uart_receive_sync_data_out_i,
  input wire uart_receive_sync_data_take_i,
  input wire sdp_scl_oe_i,
  input wire sdp_scl_out_i,
  input wire sdp_scl_take_i,
  input wire uart_transmit_sync_clock_oe_i,
  input wire uart_transmit_sync_clock_out_i,
  input wire uart_transmit_sync_clock_take_i,
  output wire [3:0] pin_raw_level_o,
  output wire [3:0] pin_owner_port_o
);
  reg [3:0] output_latch;
  reg [3:0] direction_bits;
  reg [3:0] analog_select_bits;
  wire [3:0] synced;
  wire [3:0] peri_oe;
  wire [3:0] peri_out;
  wire [3:0] peri_take;
  wire [3:0] port_b_pin_level;

  // Highest-priority function per pin, pin 7 first
  // fixed peripheral map
  assign peri_oe = {uart_transmit_sync_clock_oe_i, sdp_scl_oe_i,
                    uart_receive_sync_data_oe_i, sdp_sda_oe_i};
  assign peri_out = {uart_transmit_sync_clock_out_i, sdp_scl_out_i,
                     uart_receive_sync_data_out_i, sdp_sda_out_i};
  assign peri_take = {uart_transmit_sync_clock_take_i, sdp_scl_take_i,
                      uart_receive_sync_data_take_i, sdp_sda_take_i};

  genvar g;
  generate
    for (g = 0; g < `PBSEL_NPIN; g = g + 1) begin : g_pin
      pbsel_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .pin_i(port_pins_7_to_4_i[g]),
        .level_o(synced[g])
      );
      // analog select kept out of drive
      pbsel_pin_arb u_arb (
        .peri_oe_i(peri_oe[g]),
        .peri_out_i(peri_out[g]),
        .peri_in_take_i(peri_take[g]),
        .dir_i(direction_bits[g]),
        .lat_i(output_latch[g]),
        .pin_out_o(port_pins_7_to_4_o[g]),
        .pin_oe_o(port_pins_7_to_4_oe_o[g]),
        .owner_o(pin_owner_port_o[g])
      );
      // each pin gated by its own bit
      assign port_b_pin_level[g] = synced[g] & ~analog_select_bits[g];
    end
  endgenerate

  // raw level always visible to analog and input users
  assign pin_raw_level_o = synced;

  function [7:0] pbsel_read_word;
    input [3:0] hi;
    begin
      pbsel_read_word = {hi, `PBSEL_LOW_ZERO};
    end
  endfunction

  // Write channel: take address and data in either order
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PBSEL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `PBSEL_OFS_PORT, `PBSEL_OFS_LAT, `PBSEL_OFS_DIR, `PBSEL_OFS_ANA: begin
            s_axi_bresp <= `PBSEL_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `PBSEL_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Address decode, shared by the write and read paths
  function pbsel_hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      pbsel_hit = (addr == ofs);
    end
  endfunction

  function pbsel_mapped;
    input [3:0] addr;
    begin
      pbsel_mapped = pbsel_hit(addr, `PBSEL_OFS_PORT) |
                     pbsel_hit(addr, `PBSEL_OFS_LAT) |
                     pbsel_hit(addr, `PBSEL_OFS_DIR) |
                     pbsel_hit(addr, `PBSEL_OFS_ANA);
    end
  endfunction

  // Read word for one offset, zero where unmapped
  function [31:0] pbsel_read_sel;
    input [3:0] addr;
    input [3:0] lvl;
    input [3:0] lat;
    input [3:0] dir;
    input [3:0] ana;
    begin
      case (addr)
        `PBSEL_OFS_PORT: begin
          pbsel_read_sel = {24'h00_0000, pbsel_read_word(lvl)};
        end
        `PBSEL_OFS_LAT: begin
          pbsel_read_sel = {24'h00_0000, pbsel_read_word(lat)};
        end
        `PBSEL_OFS_DIR: begin
          pbsel_read_sel = {24'h00_0000, pbsel_read_word(dir)};
        end
        `PBSEL_OFS_ANA: begin
          pbsel_read_sel = {24'h00_0000, pbsel_read_word(ana)};
        end
        default: begin
          pbsel_read_sel = 32'h0000_0000;
        end
      endcase
    end
  endfunction

  // Write enables: only byte lane zero carries bits 7..4
  wire lane0;
  wire latch_we;
  wire dir_we;
  wire ana_we;
  wire [3:0] w_field;
  assign lane0 = w_strb[0];
  assign w_field = w_data[`PBSEL_PIN_HI:`PBSEL_PIN_LO];

  // port writes land in the latch
  assign latch_we = do_write & lane0 &
                    (pbsel_hit(aw_addr, `PBSEL_OFS_PORT) | pbsel_hit(aw_addr, `PBSEL_OFS_LAT));
  assign dir_we = do_write & lane0 & pbsel_hit(aw_addr, `PBSEL_OFS_DIR);
  assign ana_we = do_write & lane0 & pbsel_hit(aw_addr, `PBSEL_OFS_ANA);

  // Next register values, held unless written
  reg [3:0] next_output_latch;
  reg [3:0] next_direction_bits;
  reg [3:0] next_analog_select_bits;

  always @* begin
    next_output_latch = output_latch;
    if (latch_we) begin
      next_output_latch = w_field;
    end
  end

  always @* begin
    next_direction_bits = direction_bits;
    if (dir_we) begin
      next_direction_bits = w_field;
    end
  end

  always @* begin
    next_analog_select_bits = analog_select_bits;
    if (ana_we) begin
      next_analog_select_bits = w_field;
    end
  end

  // Latch holds across rst_b_i reset and gets no value at power-on: no reset branch
  // latch unaffected by bus reset
  always @(posedge clk_sys_i) begin
    output_latch <= next_output_latch;
  end

  // Direction and analog select come up as inputs, analog
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      direction_bits <= `PBSEL_DIR_RST;
      analog_select_bits <= `PBSEL_ANA_RST;
    end else begin
      direction_bits <= next_direction_bits;
      analog_select_bits <= next_analog_select_bits;
    end
  end

  // Read answer prepared from the address on the bus
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  always @* begin
    next_rdata = pbsel_read_sel(s_axi_araddr, port_b_pin_level, output_latch,
                                direction_bits, analog_select_bits);
    next_rresp = `PBSEL_RESP_OKAY;
    if (!pbsel_mapped(s_axi_araddr)) begin
      next_rresp = `PBSEL_RESP_SLVERR;
    end
  end

  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PBSEL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> shared/pbsel_map.vh
// Register offsets, field positions and reset values for the port B pin select block
`ifndef PBSEL_MAP_VH
`define PBSEL_MAP_VH
`define PBSEL_OFS_PORT 4'h0
`define PBSEL_OFS_LAT 4'h4
`define PBSEL_OFS_DIR 4'h8
`define PBSEL_OFS_ANA 4'hc
`define PBSEL_ADDR_W 4
`define PBSEL_PIN_LO 4
`define PBSEL_PIN_HI 7
`define PBSEL_NPIN 4
`define PBSEL_DIR_RST 4'hf
`define PBSEL_ANA_RST 4'hf
`define PBSEL_LAT_RST 4'h0
`define PBSEL_LOW_ZERO 4'h0
`define PBSEL_RESP_OKAY 2'h0
`define PBSEL_RESP_SLVERR 2'h2
`define PBSEL_FN_PERI 1'b0
`define PBSEL_FN_PORT 1'b1
`endif

// >>> design/pbsel_sync.v
// Three-stage pin synchroniser, change taken when stages two and three agree
`include "pbsel_map.vh"
module pbsel_sync (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire pin_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule

// >>> design/pbsel_pin_arb.v
// Per-pin output arbitration between the priority peripheral and port control
`include "pbsel_map.vh"
module pbsel_pin_arb (
  input wire peri_oe_i,
  input wire peri_out_i,
  input wire peri_in_take_i,
  input wire dir_i,
  input wire lat_i,
  output wire pin_out_o,
  output wire pin_oe_o,
  output wire owner_o
);
  // Peripheral owns pin when driving or taking it as input
  wire peri_owns;
  assign peri_owns = peri_oe_i | peri_in_take_i;
  assign owner_o = peri_owns ? `PBSEL_FN_PERI : `PBSEL_FN_PORT;
  // Port drives only when direction is output; analog select not involved
  assign pin_oe_o = peri_owns ? peri_oe_i : ~dir_i;
  assign pin_out_o = peri_owns ? peri_out_i : lat_i;
endmodule

// >>> verif/pbsel_props.sv
// Port-level checker for the port B pin select block
module pbsel_props (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] port_pins_7_to_4_i,
  input wire [3:0] port_pins_7_to_4_o,
  input wire [3:0] port_pins_7_to_4_oe_o,
  input wire sdp_sda_oe_i,
  input wire sdp_sda_out_i,
  input wire uart_transmit_sync_clock_take_i,
  input wire [3:0] pin_raw_level_o,
  input wire [3:0] pin_owner_port_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_quiet: assert property (!s_axi_rvalid && !s_axi_arvalid |=> !s_axi_rvalid)
    else $error("read answer without request");
  a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_low_zero: assert property (s_axi_rvalid |-> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("unused read bits set");
  a_sda_wins: assert property (sdp_sda_oe_i |-> !pin_owner_port_o[0] && port_pins_7_to_4_oe_o[0]
    && port_pins_7_to_4_o[0] == sdp_sda_out_i)
    else $error("pin 4 not given to serial data");
  a_take_wins: assert property (uart_transmit_sync_clock_take_i |-> !pin_owner_port_o[3])
    else $error("pin 7 input function lost");
  a_sync_level: assert property ($stable(port_pins_7_to_4_i) [*7] |-> pin_raw_level_o == port_pins_7_to_4_i)
    else $error("pin level not followed");
  a_sync_delay: assert property ($changed(port_pins_7_to_4_i[0]) |=> $stable(pin_raw_level_o[0]))
    else $error("pin level not synchronised");
endmodule
bind pbsel_top pbsel_props u_pbsel_props (.*);

// >>> verif/pbsel_pins.sv
// Circuit outside the four pins
module pbsel_pins (
  input wire clk_sys_i,
  input wire [3:0] drv_i,
  input wire [3:0] drv_oe_i,
  input wire [3:0] ext_i,
  input wire [3:0] ext_en_i,
  output logic [3:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] last;
  // Undriven pin shows the inverse of its last level
  always_ff @(posedge clk_sys_i) last <= pin_o;
  assign pin_o = (drv_oe_i & drv_i) | (~drv_oe_i & ((ext_en_i & ext_i) | (~ext_en_i & ~last)));
endmodule

// >>> verif/pbsel_top_tb.sv
// Self-checking bench of the port B pin select block
`include "pbsel_map.vh"
module pbsel_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'h0, rst_b_i = 1'h0, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, p, q, t, ext, en, v, a, l;
  logic [3:0] port_pins_7_to_4_i, port_pins_7_to_4_o, port_pins_7_to_4_oe_o;
  logic [3:0] pin_raw_level_o, pin_owner_port_o;
  logic [33:0] exp_q[$];
  int seed = 26996, error_cnt = 0, checks = 0;
  wire sdp_sda_oe_i = p[0], sdp_sda_out_i = q[0], sdp_sda_take_i = t[0];
  wire uart_receive_sync_data_oe_i = p[1], uart_receive_sync_data_out_i = q[1];
  wire uart_receive_sync_data_take_i = t[1], sdp_scl_oe_i = p[2], sdp_scl_out_i = q[2];
  wire sdp_scl_take_i = t[2], uart_transmit_sync_clock_oe_i = p[3];
  wire uart_transmit_sync_clock_out_i = q[3], uart_transmit_sync_clock_take_i = t[3];
  initial forever #20 clk_sys_i = ~clk_sys_i;
  pbsel_top u_pbsel_top (.*);
  pbsel_pins u_pbsel_pins (.clk_sys_i(clk_sys_i), .drv_i(port_pins_7_to_4_o),
    .drv_oe_i(port_pins_7_to_4_oe_o), .ext_i(ext), .ext_en_i(en), .pin_o(port_pins_7_to_4_i));
  task check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  task rd(input logic [3:0] ad, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  initial begin
    #400000;
    error_cnt++;
    final_report;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, p, q, t, ext} = 56'h0;
    s_axi_wstrb = 4'hf;
    en = 4'hf;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    @(posedge clk_sys_i);
    rd(`PBSEL_OFS_DIR, 34'h0f0);
    rd(`PBSEL_OFS_ANA, 34'h0f0);
    rd(4'h2, 34'h200000000);
    wr(`PBSEL_OFS_PORT, 32'h0, 2'h0);
    wr(`PBSEL_OFS_LAT, 32'h0, 2'h0);
    wr(`PBSEL_OFS_ANA, 32'h0, 2'h0);
    wr(`PBSEL_OFS_DIR, 32'hf0, 2'h0);
    $display("test 1 done");
    repeat (4) begin
      v = 4'($random(seed));
      ext <= v;
      repeat (6) @(posedge clk_sys_i);
      rd(`PBSEL_OFS_PORT, {26'h0, v, 4'h0});
      a = 4'($random(seed));
      wr(`PBSEL_OFS_ANA, {24'h0, a, 4'h0}, 2'h0);
      rd(`PBSEL_OFS_PORT, {26'h0, v & ~a, 4'h0});
      check(pin_raw_level_o, v);
      wr(`PBSEL_OFS_ANA, 32'h0, 2'h0);
    end
    $display("test 2 done");
    en <= 4'h0;
    wr(`PBSEL_OFS_ANA, 32'hf0, 2'h0);
    wr(`PBSEL_OFS_DIR, 32'h0, 2'h0);
    repeat (3) begin
      l = 4'($random(seed));
      wr(`PBSEL_OFS_PORT, {24'hff, l, 4'hf}, 2'h0);
      @(posedge clk_sys_i);
      check(port_pins_7_to_4_oe_o, 4'hf);
      check(port_pins_7_to_4_o, l);
      rd(`PBSEL_OFS_PORT, 34'h0);
      rd(`PBSEL_OFS_LAT, {26'h0, l, 4'h0});
      check(pin_raw_level_o, l);
    end
    $display("test 3 done");
    repeat (8) begin
      {p, q, t} <= 12'($random(seed));
      @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      check(pin_owner_port_o, 4'(~(p | t)));
      check(port_pins_7_to_4_o & p, q & p);
      check(port_pins_7_to_4_oe_o & p, p);
    end
    {p, q, t} <= 12'h0;
    rst_b_i <= 1'h0;
    @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    @(posedge clk_sys_i);
    rd(`PBSEL_OFS_LAT, {26'h0, l, 4'h0});
    rd(`PBSEL_OFS_DIR, 34'h0f0);
    $display("test 4 done");
    final_report;
  end
endmodule
